/* File: design/agcr_pkg.sv */
// Constants and carrier types for the acquisition register bank: gain,
// counter-chip ports, user-counter clock gating and the residual counter.
// Assumes the bank sits behind a byte-wide register port decoded by the
// board's bus bridge, and that the timer chip itself lives outside.

package agcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets within the acquisition register window
    localparam logic [3:0] OFF_GAIN = 4'h7;
    localparam logic [3:0] OFF_USER_CTR = 4'h8;
    localparam logic [3:0] OFF_PACER_LO = 4'h9;
    localparam logic [3:0] OFF_PACER_HI = 4'hA;
    localparam logic [3:0] OFF_CTR_CTRL = 4'hB;
    localparam logic [3:0] OFF_CLK_CTRL = 4'hC;
    localparam logic [3:0] OFF_RES_LO = 4'hD;
    localparam logic [3:0] OFF_RES_HI = 4'hE;

    ////////////////////////////////////////////////////////////////////////
    // Field layouts
    localparam int GAIN_W = 2;
    localparam int RES_W = 10;
    localparam int RES_HI_W = 2;
    localparam logic [1:0] GAIN_10V = 2'h0;
    localparam logic [1:0] GAIN_5V = 2'h1;
    localparam logic [1:0] GAIN_2V5 = 2'h2;
    localparam logic [1:0] GAIN_1V25 = 2'h3;
    localparam int CLK_SEL_BIT = 0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // FIFO sizing
    localparam int LEVEL_W = 11;
    localparam logic [10:0] FIFO_DEPTH = 11'h400;
    localparam logic [10:0] FIFO_HALF = 11'h200;

    ////////////////////////////////////////////////////////////////////////
    // Timing: onboard user clock derived from the system clock
    localparam int CLK_HZ = 10000000;
    localparam int ONBOARD_HZ = 100000;
    localparam int ONBOARD_HALF_CYC = CLK_HZ / (2 * ONBOARD_HZ);
    localparam int DIV_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [3:0] addr;
        logic [7:0] wrData;
    } agcr_bus_req_t;

    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [1:0] addr;
        logic [7:0] wrData;
    } agcr_ctr_port_t;

    typedef enum logic [1:0] {
        RES_IDLE = 2'b00,
        RES_WAIT_HF = 2'b01,
        RES_COUNT = 2'b10,
        RES_DONE = 2'b11
    } agcr_res_state_t;

endpackage

/* File: design/agcr_clkdiv.sv */
// Divider that derives the onboard 100 kHz user clock from the system clock.
// Assumes clk runs at the rate given in the package.
`timescale 1ns/1ns
`default_nettype none

module agcr_clkdiv (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    output logic clkOut
);
    import agcr_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic lvl;
    } agcr_div_state_t;

    agcr_div_state_t q;
    agcr_div_state_t d;

    localparam logic [DIV_W-1:0] LAST = DIV_W'(ONBOARD_HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Toggle the level every half period
    always_comb begin
        d = q;
        if (q.cnt == LAST) begin
            d.cnt = '0;
            d.lvl = ~q.lvl;
        end else begin
            d.cnt = q.cnt + DIV_W'(1);
        end
    end

    // Synchronous reset; a low enable freezes the phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign clkOut = q.lvl; // Straight from the flop

endmodule // agcr_clkdiv

`default_nettype wire

/* File: design/agcr_regs.sv */
// Acquisition register bank: gain select, timer-chip access ports, user
// counter clock gating, pacer chaining, FIFO fill tracking and the residual
// sample counter that raises the end-of-acquisition status.
// Assumes a byte register port with one-cycle read/write strobes, an external
// timer chip with an asynchronous read bus, and FIFO push/pop pulses.
`timescale 1ns/1ns
`default_nettype none

module agcr_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire agcr_pkg::agcr_bus_req_t busReq,
    output logic [7:0] rdData,
    output logic rdValid,
    output agcr_pkg::agcr_ctr_port_t ctrPort,
    input wire logic [7:0] ctrRdData,
    input wire logic extCtrClk,
    output logic userCtrClk,
    input wire logic pacerLowOut,
    output logic pacerHighClk,
    input wire logic unipolarSwitch,
    output logic rangeUnipolar,
    output logic [1:0] gainSel,
    input wire logic fifoPush,
    input wire logic fifoPop,
    output logic fifoHalfFull,
    input wire logic acquisitionEndIrqSelect,
    input wire logic irqFlagClear,
    output logic acquisitionEndFlag,
    output logic acquisitionEndIrq
);
    import agcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic clkGateSel;
        logic [7:0] resLow;
        logic [RES_HI_W-1:0] resHigh;
        logic [RES_W-1:0] resCount;
        agcr_res_state_t resState;
        logic endFlag;
        logic endIrq;
        logic [LEVEL_W-1:0] level;
        logic halfFull;
        logic selPrev;
        logic [7:0] rdData;
        logic rdValid;
        logic ctrRdPend;
        agcr_ctr_port_t ctr;
        logic userClk;
        logic pacerClk;
        logic unipolar;
    } agcr_state_t;

    agcr_state_t q;
    agcr_state_t d;
    logic onboardClk;

    ////////////////////////////////////////////////////////////////////////
    // Onboard user clock source
    agcr_clkdiv i_agcr_clkdiv (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clkOut(onboardClk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    logic isCtrAddr;
    logic [1:0] ctrIdx;
    logic [LEVEL_W-1:0] levelNext;
    logic hfRise;
    logic selRise;
    logic resWrite;

    // Counter-chip ports occupy four consecutive offsets
    assign isCtrAddr = (busReq.addr >= OFF_USER_CTR) && (busReq.addr <= OFF_CTR_CTRL);
    assign ctrIdx = 2'(busReq.addr - OFF_USER_CTR);
    assign resWrite = busReq.wrEn && ((busReq.addr == OFF_RES_LO) || (busReq.addr == OFF_RES_HI));

    // FIFO level; a push into a full FIFO is dropped, a pop from empty ignored
    always_comb begin
        levelNext = q.level;
        if (fifoPush && !fifoPop && (q.level < FIFO_DEPTH)) begin
            levelNext = q.level + LEVEL_W'(1);
        end else if (fifoPop && !fifoPush && (q.level != '0)) begin
            levelNext = q.level - LEVEL_W'(1);
        end
    end

    assign hfRise = (levelNext >= FIFO_HALF) && !q.halfFull;
    assign selRise = acquisitionEndIrqSelect && !q.selPrev;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        d = q;
        d.rdValid = 1'b0;
        d.ctrRdPend = 1'b0;
        d.ctr.wrStb = 1'b0;
        d.ctr.rdStb = 1'b0;
        d.selPrev = acquisitionEndIrqSelect;
        d.unipolar = unipolarSwitch;
        d.pacerClk = pacerLowOut;
        d.level = levelNext;
        d.halfFull = (levelNext >= FIFO_HALF);

        // User counter clock: gated onboard clock or the pin alone
        if (q.clkGateSel) begin
            d.userClk = onboardClk & extCtrClk;
        end else begin
            d.userClk = extCtrClk;
        end

        // Register writes; counter-chip writes pass through as one strobe
        if (busReq.wrEn) begin
            case (busReq.addr)
                OFF_GAIN: d.gain = busReq.wrData[GAIN_W-1:0];
                OFF_CLK_CTRL: d.clkGateSel = busReq.wrData[CLK_SEL_BIT];
                OFF_RES_LO: d.resLow = busReq.wrData;
                OFF_RES_HI: d.resHigh = busReq.wrData[RES_HI_W-1:0];
                default: d.ctr.wrStb = isCtrAddr;
            endcase
            if (isCtrAddr) begin
                d.ctr.addr = ctrIdx;
                d.ctr.wrData = busReq.wrData;
            end
        end

        // Reads: local registers answer next cycle, the chip one later
        if (busReq.rdEn) begin
            if (isCtrAddr) begin
                d.ctr.rdStb = 1'b1;
                d.ctr.addr = ctrIdx;
                d.ctrRdPend = 1'b1;
            end else begin
                d.rdValid = 1'b1;
                case (busReq.addr)
                    OFF_GAIN: d.rdData = {6'h00, q.gain};
                    OFF_CLK_CTRL: d.rdData = {7'h00, q.clkGateSel};
                    OFF_RES_LO: d.rdData = q.resLow;
                    OFF_RES_HI: d.rdData = {6'h00, q.resHigh};
                    default: d.rdData = READ_ZERO; // Unmapped reads as zero
                endcase
            end
        end
        if (q.ctrRdPend) begin
            d.rdData = ctrRdData; // Chip read bus settled during its strobe
            d.rdValid = 1'b1;
        end

        // Residual counter sequencing
        case (q.resState)
            RES_IDLE: begin
                if (selRise) begin
                    // Armed before any sample: count from the first one
                    // Empty FIFO at arming and a residual below 512: the first interrupt is the end one
                    d.resState = (q.level == '0) ? RES_COUNT : RES_WAIT_HF;
                end
            end
            RES_WAIT_HF: begin
                if (hfRise) begin
                    d.resState = RES_COUNT;
                end
            end
            RES_COUNT: begin
                if (q.resCount == '0) begin
                    d.endFlag = 1'b1;
                    d.resState = RES_DONE;
                end else if (fifoPush) begin
                    d.resCount = q.resCount - RES_W'(1);
                    if (q.resCount == RES_W'(1)) begin
                        d.endFlag = 1'b1;
                        d.resState = RES_DONE;
                    end
                end
            end
            RES_DONE: d.resState = RES_DONE;
            default: d.resState = RES_IDLE;
        endcase

        // Dropping the select disarms; done waits here until then
        if (!acquisitionEndIrqSelect) begin
            d.resState = RES_IDLE;
        end

        // Reload on any residual write, using the bytes just written
        if (resWrite) begin
            d.resCount = {d.resHigh, d.resLow};
            d.resState = RES_IDLE;
        end

        // Flag clear loses to a same-cycle set so no event is missed
        if (irqFlagClear && !(d.endFlag && !q.endFlag)) begin
            d.endFlag = 1'b0;
        end
        d.endIrq = d.endFlag && acquisitionEndIrqSelect;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state record
    assign rdData = q.rdData;
    assign rdValid = q.rdValid;
    assign ctrPort = q.ctr;
    assign userCtrClk = q.userClk;
    assign pacerHighClk = q.pacerClk;
    assign rangeUnipolar = q.unipolar;
    assign gainSel = q.gain;
    assign fifoHalfFull = q.halfFull;
    assign acquisitionEndFlag = q.endFlag;
    assign acquisitionEndIrq = q.endIrq;

endmodule // agcr_regs

`default_nettype wire

/* File: verification/agcr_regs_sva.sv */
// Checker for the acquisition register bank, bound to its top module.
// Assumes the port list of agcr_regs and the offsets of the package.
`timescale 1ns/1ns
`default_nettype none
module agcr_regs_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire agcr_pkg::agcr_bus_req_t busReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire agcr_pkg::agcr_ctr_port_t ctrPort,
    input wire logic [7:0] ctrRdData,
    input wire logic extCtrClk,
    input wire logic userCtrClk,
    input wire logic pacerLowOut,
    input wire logic pacerHighClk,
    input wire logic unipolarSwitch,
    input wire logic rangeUnipolar,
    input wire logic [1:0] gainSel,
    input wire logic fifoPush,
    input wire logic fifoPop,
    input wire logic fifoHalfFull,
    input wire logic acquisitionEndIrqSelect,
    input wire logic irqFlagClear,
    input wire logic acquisitionEndFlag,
    input wire logic acquisitionEndIrq
);
    import agcr_pkg::*;
    logic clkSel_q;
    logic [10:0] level_q;
    logic [10:0] level_d;
    wire logic clkWr = ce && busReq.wrEn && busReq.addr == OFF_CLK_CTRL;
    // Running edge: the edge that releases reset still loads reset values
    wire logic run = ce && rst_n;
    ////////////////////////////////////////
    // Shadow fill level; pushes past full are dropped like the bank does
    always_comb begin
        level_d = level_q;
        if (ce && fifoPush && !fifoPop && level_q < FIFO_DEPTH) level_d = level_q + 11'h001;
        if (ce && fifoPop && !fifoPush && level_q != 11'h000) level_d = level_q - 11'h001;
    end
    // Shadow of the clock select bit and the level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clkSel_q <= 1'b0;
            level_q <= 11'h000;
        end else begin
            level_q <= level_d;
            if (clkWr) clkSel_q <= busReq.wrData[CLK_SEL_BIT];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    property p_gain;
        ce && busReq.wrEn && busReq.addr == OFF_GAIN |=> gainSel == $past(busReq.wrData[1:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain select not taken");
    property p_range;
        run |=> rangeUnipolar == $past(unipolarSwitch);
    endproperty
    a_range: assert property (p_range) else $error("range not from switch");
    property p_ctrWr;
        ce && busReq.wrEn && busReq.addr[3:2] == 2'b10 |=> ctrPort.wrStb
            && ctrPort.addr == $past(busReq.addr[1:0]) && ctrPort.wrData == $past(busReq.wrData);
    endproperty
    a_ctrWr: assert property (p_ctrWr) else $error("counter write lost");
    property p_ctrRd;
        ce && busReq.rdEn && busReq.addr[3:2] == 2'b10 |=> ctrPort.rdStb
            ##1 (rdValid && rdData == $past(ctrRdData));
    endproperty
    a_ctrRd: assert property (p_ctrRd) else $error("counter read wrong");
    property p_extOnly;
        run && !clkSel_q && !clkWr |=> userCtrClk == $past(extCtrClk);
    endproperty
    a_extOnly: assert property (p_extOnly) else $error("user clock not external");
    property p_gated;
        ce && clkSel_q && !clkWr && !extCtrClk |=> !userCtrClk;
    endproperty
    a_gated: assert property (p_gated) else $error("user clock not gated");
    property p_pacer;
        run |=> pacerHighClk == $past(pacerLowOut);
    endproperty
    a_pacer: assert property (p_pacer) else $error("pacer chain broken");
    property p_half;
        fifoHalfFull == (level_q >= FIFO_HALF);
    endproperty
    a_half: assert property (p_half) else $error("half full wrong");
    property p_clear;
        ce && acquisitionEndFlag && irqFlagClear && !fifoPush && !acquisitionEndIrqSelect
            |=> !acquisitionEndFlag;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_irq;
        run |=> acquisitionEndIrq == (acquisitionEndFlag && $past(acquisitionEndIrqSelect));
    endproperty
    a_irq: assert property (p_irq) else $error("irq not flag and select");
endmodule // agcr_regs_sva
bind agcr_regs agcr_regs_sva i_agcr_regs_sva (.clk, .rst_n, .ce, .busReq, .rdData, .rdValid,
    .ctrPort, .ctrRdData, .extCtrClk, .userCtrClk, .pacerLowOut, .pacerHighClk,
    .unipolarSwitch, .rangeUnipolar, .gainSel, .fifoPush, .fifoPop, .fifoHalfFull,
    .acquisitionEndIrqSelect, .irqFlagClear, .acquisitionEndFlag, .acquisitionEndIrq);
`default_nettype wire

/* File: verification/agcr_timer_model.sv */
// Behavioural timer chip: four byte ports and a free pacer low output.
// Assumes the bank's registered strobes; read bus is live only under rdStb.
`timescale 1ns/1ns
`default_nettype none
module agcr_timer_model (
    input wire logic clk,
    input wire agcr_pkg::agcr_ctr_port_t ctrPort,
    output logic [7:0] ctrRdData,
    output logic pacerLowOut
);
    import agcr_pkg::*;
    logic [7:0] mem [4];
    logic [7:0] fill = 8'h5A;
    logic [1:0] div = 2'h0;
    // Ports store writes; idle bus toggles so stale data never matches
    always @(posedge clk) begin
        if (ctrPort.wrStb) mem[ctrPort.addr] <= ctrPort.wrData;
        fill <= ~fill;
        div <= div + 2'h1;
    end
    assign ctrRdData = ctrPort.rdStb ? mem[ctrPort.addr] : fill;
    assign pacerLowOut = div[1];
endmodule // agcr_timer_model
`default_nettype wire

/* File: verification/agcr_regs_test.sv */
// Self-checking bench for the acquisition register bank.
// Assumes the timer model on the counter port; ce drops once to check the freeze.
`timescale 1ns/1ns
`default_nettype none
module agcr_regs_test;
    import agcr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    agcr_bus_req_t busReq = '0;
    agcr_ctr_port_t ctrPort;
    logic [7:0] rdData, ctrRdData, q, d;
    logic [1:0] gainSel;
    logic rdValid, userCtrClk, pacerLowOut, pacerHighClk, rangeUnipolar, fifoHalfFull;
    logic extCtrClk = 1'b1, unipolarSwitch = 1'b0, fifoPush = 1'b0, fifoPop = 1'b0;
    logic sel = 1'b0, clr = 1'b0, flag, irq;
    logic ce = 1'b1;
    int miscompares = 0, checked = 0, n, k, m;
    agcr_regs i_agcr_regs (.clk, .rst_n, .ce, .busReq, .rdData, .rdValid, .ctrPort,
        .ctrRdData, .extCtrClk, .userCtrClk, .pacerLowOut, .pacerHighClk, .unipolarSwitch,
        .rangeUnipolar, .gainSel, .fifoPush, .fifoPop, .fifoHalfFull,
        .acquisitionEndIrqSelect(sel), .irqFlagClear(clr), .acquisitionEndFlag(flag),
        .acquisitionEndIrq(irq));
    agcr_timer_model i_agcr_timer_model (.clk, .ctrPort, .ctrRdData, .pacerLowOut);
    initial begin
        forever #50 clk = ~clk;
    end
    // Pins that wander freely: external clock and polarity switch
    always @(posedge clk) begin
        extCtrClk <= 1'($urandom);
        unipolarSwitch <= 1'($urandom);
    end
    ////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One bus cycle; a read waits a bounded time for its answer
    task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) busReq <= '{wrEn: w, rdEn: !w, addr: a, wrData: v};
        @(posedge clk) busReq <= '0;
        if (w) return;
        repeat (4) begin
            @(negedge clk);
            if (rdValid === 1'b1) begin
                q = rdData;
                return;
            end
        end
        miscompares++;
        final_report();
    endtask
    task fifo(input logic p, input int c);
        repeat (c) @(posedge clk) begin
            fifoPush <= p;
            fifoPop <= !p;
        end
        @(posedge clk) begin
            fifoPush <= 1'b0;
            fifoPop <= 1'b0;
        end
        @(negedge clk);
    endtask
    // End service: drop select, drain, then pulse the flag clear
    task service(input int c);
        @(posedge clk) sel <= 1'b0;
        fifo(1'b0, c);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        @(negedge clk);
        chk("flagCleared", flag, 1'b0);
    endtask
    function logic [7:0] rdMask(input logic [3:0] a, input logic [7:0] v);
        case (a)
            OFF_GAIN, OFF_RES_HI: return {6'h00, v[1:0]};
            OFF_CLK_CTRL: return {7'h00, v[0]};
            OFF_USER_CTR, OFF_PACER_LO, OFF_PACER_HI, OFF_CTR_CTRL, OFF_RES_LO: return v;
            default: return READ_ZERO;
        endcase
    endfunction
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h59CB));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("gainReset", gainSel, 2'h0);
        for (n = 0; n < 4; n++) begin
            bus(1'b1, OFF_GAIN, 8'hFC | 8'(n));
            @(negedge clk);
            chk("gainSel", gainSel, n[1:0]);
        end
        // Enable low: a gain write must not land while the bank is frozen
        @(posedge clk) ce <= 1'b0;
        bus(1'b1, OFF_GAIN, 8'h01);
        @(negedge clk);
        chk("ceFreeze", gainSel, 2'h3);
        @(posedge clk) ce <= 1'b1;
        // Every offset, unmapped ones too, written and read back
        repeat (3) for (n = 0; n < 16; n++) begin
            d = 8'($urandom);
            bus(1'b1, n[3:0], d);
            bus(1'b0, n[3:0], 8'h00);
            chk("readBack", q, rdMask(n[3:0], d));
        end
        // Select low: samples arrive but no end status
        bus(1'b1, OFF_RES_LO, 8'h03);
        bus(1'b1, OFF_RES_HI, 8'h00);
        fifo(1'b1, 3);
        chk("noSelect", flag, 1'b0);
        fifo(1'b0, 3);
        for (k = 0; k < 4; k++) begin
            n = (k == 0) ? 1 : (k == 1) ? 1023 : 1 + int'($urandom_range(600));
            bus(1'b1, OFF_RES_LO, n[7:0]);
            bus(1'b1, OFF_RES_HI, {6'h00, n[9:8]});
            @(posedge clk) sel <= 1'b1;
            // Above half a FIFO: drain 512 on half full, the rest at the end
            m = (n > 512) ? 512 : 0;
            if (m > 0) begin
                fifo(1'b1, m);
                chk("halfIrq", fifoHalfFull, 1'b1);
                fifo(1'b0, m);
            end
            fifo(1'b1, n - m - 1);
            chk("flagEarly", flag, 1'b0);
            fifo(1'b1, 1);
            chk("flagEnd", flag, 1'b1);
            chk("irqEnd", irq, 1'b1);
            service(n - m);
        end
        // Queue not empty: counting waits for the half-full crossing
        bus(1'b1, OFF_RES_LO, 8'h07);
        bus(1'b1, OFF_RES_HI, 8'h00);
        fifo(1'b1, 1);
        @(posedge clk) sel <= 1'b1;
        fifo(1'b1, 510);
        chk("below", fifoHalfFull, 1'b0);
        chk("waitHalf", flag, 1'b0);
        fifo(1'b1, 1);
        chk("atHalf", fifoHalfFull, 1'b1);
        fifo(1'b1, 5);
        chk("counting", flag, 1'b0);
        fifo(1'b1, 2);
        chk("residual", flag, 1'b1);
        service(519);
        final_report();
    end
endmodule // agcr_regs_test
`default_nettype wire
